/* File: verification/tb_tril_core.sv */
`timescale 1ns/100ps
module tb_tril_core import tril_pkg::*; ;
   logic clk_sys = 1'b0; // 200 MHz
   logic srst = 1'b1; // reset
   tril_reg_req_t reg_req = '0; // register request
   logic [15:0] reg_rdata; // read data
   logic reg_rvalid; // read valid
   logic [19:0] sensor_en = '0; // sensors
   logic [19:0] btn_en = '0; // button outputs
   logic [19:0] led_en = '0; // led drivers
   logic conv_start; // start
   logic [4:0] conv_chan; // channel
   tril_conv_res_t conv_res; // result
   logic gpio_in, gpio_out, gpio_oe; // gpio pin
   logic gpio_drv = 1'b0; // level driven by the bench
   logic strap = 1'b0; // polarity strap
   logic event_irq_n; // interrupt pin
   logic [31:0] touch = '0; // finger pattern
   logic slow = 1'b0; // slow converter
   logic [15:0] d; // read result
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   assign gpio_in = gpio_oe ? gpio_out : gpio_drv; // wire level
   always #2.5 clk_sys = ~clk_sys;
   tril_core u_tril_core (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sensor_en(sensor_en),
      .button_emulation_en(btn_en), .led_drive_en(led_en), .conv_start(conv_start),
      .conv_chan(conv_chan), .conv_res(conv_res), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .irq_pol_strap(strap), .event_irq_n(event_irq_n));
   tril_conv_model u_tril_conv_model (.clk_sys(clk_sys), .srst(srst),
      .conv_start(conv_start), .conv_chan(conv_chan), .touch_mask(touch), .slow(slow),
      .conv_res(conv_res));
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_sim();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task do_reset(input logic pol);
      srst = 1'b1;
      strap = pol;
      repeat (6) @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
   endtask : do_reset
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(negedge clk_sys);
      reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(negedge clk_sys);
      reg_req.wr = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [15:0] v);
      @(negedge clk_sys);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(negedge clk_sys);
      v = reg_rvalid ? reg_rdata : 16'hxxxx; // no answer never matches
      reg_req.rd = 1'b0;
   endtask : rd
   // wait for the pin to reach its active or idle level
   task wait_irq(input logic act);
      int n;
      n = 0;
      while (event_irq_n !== (act ~^ strap) && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      chk({15'h0, event_irq_n}, {15'h0, act ~^ strap}, "irq level");
   endtask : wait_irq
   task clr;
      rd(OFS_STAT_LO, d);
      rd(OFS_STAT_HI, d);
   endtask : clr
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk({14'h0, gpio_oe, gpio_out}, 16'h0002, "gpio after reset");
      chk({15'h0, event_irq_n}, 16'h0001, "irq idle");
      rd(OFS_GPIO_CFG, d);
      chk(d, 16'h0002, "gpio cfg reset");
      rd(8'h30, d);
      chk(d, 16'h0000, "unmapped read");
   endtask : t_reset
   // one gpio input trigger: arm at idle level, hit, return to idle, read
   task t_trig(input logic [2:0] tg, input logic idle, input logic hit);
      gpio_drv = idle;
      wr(OFS_GPIO_CFG, {11'h000, tg, GPIO_FN_IN});
      repeat (5) @(negedge clk_sys);
      clr();
      wait_irq(1'b0);
      gpio_drv = hit;
      wait_irq(1'b1);
      // level gone before the read, so the flag cannot re-arm
      gpio_drv = idle;
      repeat (4) @(negedge clk_sys);
      rd(OFS_STAT_HI, d);
      chk({15'h0, d[GPIO_STAT_BIT]}, 16'h0001, "gpio status");
      wait_irq(1'b0);
   endtask : t_trig
   task t_gpio;
      for (int f = 0; f < 4; f++) begin
         wr(OFS_GPIO_CFG, {14'h0, f[1:0]});
         repeat (3) @(negedge clk_sys);
         chk({14'h0, gpio_oe, gpio_oe & gpio_out}, {14'h0, f[1], f[1] & f[0]}, "fn");
      end
      // every trigger code the input mode decodes
      t_trig(TRIG_RISE, 1'b0, 1'b1);
      t_trig(TRIG_FALL, 1'b1, 1'b0);
      t_trig(TRIG_BOTH, 1'b0, 1'b1);
      t_trig(TRIG_LOW, 1'b1, 1'b0);
      t_trig(TRIG_HIGH, 1'b0, 1'b1);
      wr(OFS_GPIO_CFG, {14'h0, GPIO_FN_LOW});
   endtask : t_gpio
   // ch 2 taken by button output, ch 5 by led driver
   task t_touch;
      sensor_en = 20'h20025;
      btn_en = 20'h00004;
      led_en = 20'h00020;
      touch = 32'hffff_ffff;
      wait_irq(1'b1);
      repeat (60) @(negedge clk_sys);
      rd(OFS_STAT_LO, d);
      chk(d, 16'h0001, "touch status low");
      rd(OFS_STAT_HI, d);
      chk(d, 16'h0002, "touch status high");
      wait_irq(1'b0);
      // converter model hands back the channel number as delta
      rd(OFS_CAP_BASE + 8'h11, d);
      chk(d, 16'h0011, "delta of channel 17");
      rd(OFS_CAP_BASE + 8'h02, d);
      chk(d, 16'h0000, "button channel converted");
      slow = 1'b1;
      touch = 32'h0;
      wait_irq(1'b1);
      repeat (120) @(negedge clk_sys);
      rd(OFS_STAT_LO, d);
      chk(d, 16'h0000, "untouch status");
      rd(OFS_STAT_HI, d);
      chk(d, 16'h0000, "untouch status high");
      slow = 1'b0;
   endtask : t_touch
   task t_slider;
      logic [15:0] cfg [3];
      logic [31:0] msk [3];
      logic [4:0] loc [3];
      int n;
      cfg = '{16'h000f, 16'h000f, 16'h040f};
      msk = '{32'h2, 32'h6, 32'h9};
      loc = '{5'd2, 5'd3, 5'd7}; // 2j, 2j+1, 2N-1 with N=4
      sensor_en = 20'h0000f;
      btn_en = '0;
      led_en = '0;
      d = 16'h0;
      for (int i = 0; i < 3; i++) begin
         wr(OFS_SLIDER_CFG, cfg[i]);
         rd(OFS_SLIDER_CFG, d);
         chk(d, cfg[i], "slider cfg");
         touch = msk[i];
         n = 0;
         while (d[4:0] !== loc[i] && n < 100) begin
            rd(OFS_SLIDER_POS, d);
            n++;
         end
         chk(d & 16'h805f, {1'b1, 8'h00, 1'b1, 1'b0, loc[i]}, "position");
         if (i == 1) chk({15'h0, d[SL_DIR_BIT]}, 16'h0001, "direction");
      end
      touch = 32'h0;
   endtask : t_slider
   task t_pol;
      do_reset(1'b1);
      chk({15'h0, event_irq_n}, 16'h0000, "irq idle inverted");
      sensor_en = 20'h00001;
      touch = 32'h1;
      wait_irq(1'b1);
      clr();
      wait_irq(1'b0);
   endtask : t_pol
   initial begin
      do_reset(1'b0);
      t_reset();
      t_gpio();
      t_touch();
      t_slider();
      t_pol();
      end_sim();
   end
endmodule : tb_tril_core

/* File: verification/tril_conv_model.sv */
`timescale 1ns/100ps
module tril_conv_model import tril_pkg::*; (
   input wire logic clk_sys, // clock
   input wire logic srst, // reset
   input wire logic conv_start, // start pulse
   input wire logic [4:0] conv_chan, // channel to convert
   input wire logic [31:0] touch_mask, // finger present per channel
   input wire logic slow, // long conversions
   output tril_conv_res_t conv_res // result
);
   logic [3:0] cnt_q; // cycles left, zero when idle
   logic [4:0] ch_q; // channel in flight
   // answer after one or nine cycles; stale fields never held
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_q <= 4'h0;
         ch_q <= 5'h00;
         conv_res <= '0;
      end else begin
         conv_res.done <= 1'b0;
         conv_res.touched <= ~conv_res.touched;
         conv_res.delta <= ~conv_res.delta;
         if (conv_start) begin
            cnt_q <= slow ? 4'h9 : 4'h1;
            ch_q <= conv_chan;
         end else if (cnt_q == 4'h1) begin
            cnt_q <= 4'h0;
            conv_res <= {1'b1, touch_mask[ch_q], 11'h000, ch_q};
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule : tril_conv_model

/* File: verification/tril_core_monitor.sv */
`timescale 1ns/100ps
module tril_core_monitor import tril_pkg::*; #(
   parameter int NUM_CH = NUM_CH_DEF
) (
   input wire logic clk_sys, // clock
   input wire logic srst, // reset
   input wire tril_reg_req_t reg_req, // register request
   input wire logic [REG_DW-1:0] reg_rdata, // read data
   input wire logic reg_rvalid, // read valid
   input wire logic [NUM_CH-1:0] sensor_en, // sensor channels
   input wire logic [NUM_CH-1:0] button_emulation_en, // button outputs
   input wire logic [NUM_CH-1:0] led_drive_en, // led drivers
   input wire logic conv_start, // conversion start
   input wire logic [$clog2(NUM_CH)-1:0] conv_chan, // converted channel
   input wire tril_conv_res_t conv_res, // converter result
   input wire logic gpio_out, // gpio drive value
   input wire logic gpio_oe, // gpio drive enable
   input wire logic irq_pol_strap, // polarity strap
   input wire logic event_irq_n // interrupt pin
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic st_rd; // read of either status word
   logic [NUM_CH-1:0] live; // channels left as sensors
   logic fn_wr; // gpio config write
   assign st_rd = reg_req.rd && (reg_req.addr == OFS_STAT_LO || reg_req.addr == OFS_STAT_HI);
   assign live = sensor_en & ~button_emulation_en & ~led_drive_en;
   assign fn_wr = reg_req.wr && reg_req.addr == OFS_GPIO_CFG;
   ////////////////////////////////////////////////////////////////////////////////
   AST_RD_ANSWER: assert property (reg_req.rd |=> reg_rvalid)
      else $error("read not answered");
   AST_RV_CAUSE: assert property (reg_rvalid |-> $past(reg_req.rd))
      else $error("read valid without read");
   AST_RD_IDLE: assert property (!reg_rvalid |-> reg_rdata == '0)
      else $error("read data not zero when idle");
   // channel choice was made one cycle before the start pulse shows
   AST_SKIP: assert property (conv_start |-> $past(live[conv_chan]))
      else $error("non-sensor channel converted");
   AST_START_PULSE: assert property (conv_start |=> !conv_start)
      else $error("start longer than one cycle");
   AST_GPIO_HIGH: assert property (fn_wr && reg_req.wdata[1:0] == GPIO_FN_HIGH
      |-> ##2 (gpio_oe && gpio_out))
      else $error("gpio not driven high");
   AST_GPIO_OFF: assert property (fn_wr && reg_req.wdata[1:0] == GPIO_FN_OFF
      |-> ##2 !gpio_oe)
      else $error("gpio still driven when off");
   AST_GPIO_RST: assert property ($fell(srst) |-> gpio_oe && !gpio_out)
      else $error("gpio not low after reset");
   AST_IRQ_CLEAR: assert property (st_rd && !conv_res.done && gpio_oe ##1 !conv_res.done
      |=> event_irq_n != irq_pol_strap)
      else $error("irq not released by status read");
   AST_IRQ_CAUSE: assert property (event_irq_n == irq_pol_strap
      && $past(event_irq_n) != irq_pol_strap
      |-> $past(conv_res.done, 2) || !gpio_oe || !$past(gpio_oe, 2))
      else $error("irq without event");
   // main scenarios seen
   cover property (st_rd ##1 reg_rvalid);
   cover property (conv_start);
   cover property (event_irq_n == irq_pol_strap);
   cover property (gpio_oe && gpio_out);
endmodule : tril_core_monitor
bind tril_core tril_core_monitor #(.NUM_CH(NUM_CH)) u_tril_core_monitor (.clk_sys(clk_sys),
   .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .sensor_en(sensor_en), .button_emulation_en(button_emulation_en),
   .led_drive_en(led_drive_en), .conv_start(conv_start), .conv_chan(conv_chan),
   .conv_res(conv_res), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
   .irq_pol_strap(irq_pol_strap), .event_irq_n(event_irq_n));

/* File: verilog/tril_core.sv */
`timescale 1ns/100ps
module tril_core import tril_pkg::*; #(
   parameter int NUM_CH = NUM_CH_DEF
) (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire tril_reg_req_t reg_req, // register read or write request
   output logic [REG_DW-1:0] reg_rdata, // read data
   output logic reg_rvalid, // read data valid pulse
   input wire logic [NUM_CH-1:0] sensor_en, // channel wired as touch sensor
   input wire logic [NUM_CH-1:0] button_emulation_en, // channel used as button output
   input wire logic [NUM_CH-1:0] led_drive_en, // channel used as led driver
   output logic conv_start, // start pulse to capacitance_converter
   output logic [$clog2(NUM_CH)-1:0] conv_chan, // channel routed to converter
   input wire tril_conv_res_t conv_res, // converter result
   input wire logic gpio_in, // gpio pin level
   output logic gpio_out, // gpio pin drive value
   output logic gpio_oe, // gpio pin drive enable
   input wire logic irq_pol_strap, // high selects active-high irq
   output logic event_irq_n // interrupt pin
);
   localparam int CH_W = $clog2(NUM_CH);
   localparam logic [CH_W-1:0] LAST_CH = CH_W'(NUM_CH - 1);

   // refuse channel counts the register layout cannot hold
   if (NUM_CH < SL_ELEMS || NUM_CH > STAT_LO_CH + GPIO_STAT_BIT) begin : g_chk
      $error("tril_core: NUM_CH out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   tril_seq_t seq_q, seq_d; // sequencer state
   logic [CH_W-1:0] chan_q, chan_d; // channel under scan
   logic start_q, start_d; // converter start pulse
   logic [NUM_CH-1:0] touch_q, touch_d; // per-channel touch status
   logic [REG_DW-1:0] cap_q [NUM_CH]; // last delta per channel
   logic [REG_DW-1:0] cap_d [NUM_CH]; // next delta per channel
   logic touch_pend_q, touch_pend_d; // touch event awaiting read
   logic gpio_flag_q, gpio_flag_d; // gpio event awaiting read
   logic [GPIO_CFG_W-1:0] gpio_cfg_q, gpio_cfg_d; // gpio function config
   logic [SL_CFG_W-1:0] sl_cfg_q, sl_cfg_d; // slider assignment
   logic [LOC_W-1:0] loc_q, loc_d; // slider location
   logic dir_q, dir_d; // slider direction
   logic sl_act_q, sl_act_d; // slider touched
   logic sl_flag_q, sl_flag_d; // slider event flag
   logic [REG_DW-1:0] rdata_q, rdata_d; // read data
   logic rvalid_q, rvalid_d; // read valid
   logic gout_q, gout_d; // gpio drive value
   logic goe_q, goe_d; // gpio drive enable
   logic irq_q, irq_d; // interrupt pin level
   logic pol_q, pol_d; // latched polarity strap
   logic g_s1_q, g_s2_q, g_s3_q; // gpio synchroniser and history
   logic p_s1_q, p_s2_q; // strap synchroniser

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers
   logic [NUM_CH-1:0] sense_mask; // channels the sequencer converts
   logic stat_rd; // completed read of a status register
   logic touch_evt; // touch status changed this cycle
   logic gpio_evt; // gpio trigger seen this cycle

   // output drivers win over sensor use
   assign sense_mask = sensor_en & ~(button_emulation_en | led_drive_en);
   assign stat_rd = reg_req.rd && (reg_req.addr == OFS_STAT_LO || reg_req.addr == OFS_STAT_HI);

   ////////////////////////////////////////////////////////////////////////////
   // scan sequencer, next values
   always_comb begin
      seq_d = seq_q;
      chan_d = chan_q;
      start_d = 1'b0;
      touch_d = touch_q;
      cap_d = cap_q;
      touch_evt = 1'b0;
      case (seq_q)
         SEQ_SCAN: begin
            if (sense_mask[chan_q]) begin
               // sensor channel: route to converter
               start_d = 1'b1;
               seq_d = SEQ_WAIT;
            end else begin
               // floating or driver channel: never converted
               chan_d = (chan_q == LAST_CH) ? '0 : chan_q + 1'b1;
            end
         end
         SEQ_WAIT: begin
            if (conv_res.done) begin
               cap_d[chan_q] = conv_res.delta;
               if (conv_res.touched != touch_q[chan_q]) begin
                  // touch writes one, untouch writes zero
                  touch_d[chan_q] = conv_res.touched;
                  touch_evt = 1'b1;
               end
               chan_d = (chan_q == LAST_CH) ? '0 : chan_q + 1'b1;
               seq_d = SEQ_SCAN;
            end
         end
         default: begin
            seq_d = SEQ_SCAN;
         end
      endcase
   end

   // scan sequencer, registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         seq_q <= SEQ_SCAN;
         chan_q <= '0;
         start_q <= 1'b0;
         touch_q <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            cap_q[i] <= '0;
         end
      end else begin
         seq_q <= seq_d;
         chan_q <= chan_d;
         start_q <= start_d;
         touch_q <= touch_d;
         cap_q <= cap_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slider and scroll position, next values
   always_comb begin
      logic [SL_ELEMS-1:0] comp; // touch of assigned elements, packed
      int n; // assigned element count
      int j; // first touched ordinal
      int pos; // interpolated position
      logic hit; // any element touched
      comp = '0;
      n = 0;
      j = 0;
      pos = 0;
      hit = 1'b0;
      // pack the assigned channels in channel order
      for (int i = 0; i < SL_ELEMS; i++) begin
         if (sl_cfg_q[i]) begin
            comp[n] = touch_q[i];
            n = n + 1;
         end
      end
      for (int i = SL_ELEMS - 1; i >= 0; i--) begin
         if (comp[i] && i < n) begin
            j = i;
            hit = 1'b1;
         end
      end
      // even codes on an element, odd codes between two
      pos = 2 * j;
      if (j + 1 < n && comp[j+1]) begin
         pos = 2 * j + 1;
      end
      if (sl_cfg_q[SL_WHEEL_BIT] && n > 1 && comp[0] && comp[n-1] && !comp[1]) begin
         pos = 2 * n - 1; // wheel wraps last to first
      end
      loc_d = loc_q;
      dir_d = dir_q;
      sl_act_d = hit;
      sl_flag_d = sl_flag_q;
      if (reg_req.rd && reg_req.addr == OFS_SLIDER_POS) begin
         sl_flag_d = 1'b0; // cleared by reading the position
      end
      if (hit && (!sl_act_q || LOC_W'(pos) != loc_q)) begin
         loc_d = LOC_W'(pos);
         dir_d = sl_act_q && (LOC_W'(pos) > loc_q);
         sl_flag_d = 1'b1; // set wins over the read
      end
   end

   // slider and scroll position, registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         loc_q <= '0;
         dir_q <= 1'b0;
         sl_act_q <= 1'b0;
         sl_flag_q <= 1'b0;
      end else begin
         loc_q <= loc_d;
         dir_q <= dir_d;
         sl_act_q <= sl_act_d;
         sl_flag_q <= sl_flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gpio trigger detect from synchronised pin
   always_comb begin
      gpio_evt = 1'b0;
      if (gpio_cfg_q[1:0] == GPIO_FN_IN) begin
         case (gpio_cfg_q[GPIO_TRIG_LSB +: 3])
            TRIG_LOW: gpio_evt = !g_s2_q;
            TRIG_HIGH: gpio_evt = g_s2_q;
            TRIG_FALL: gpio_evt = g_s3_q && !g_s2_q;
            TRIG_RISE: gpio_evt = !g_s3_q && g_s2_q;
            TRIG_BOTH: gpio_evt = g_s3_q != g_s2_q;
            default: gpio_evt = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port, interrupt and gpio pin, next values
   always_comb begin
      gpio_cfg_d = gpio_cfg_q;
      sl_cfg_d = sl_cfg_q;
      rdata_d = '0;
      rvalid_d = reg_req.rd;
      // writes to the two configuration registers
      if (reg_req.wr && reg_req.addr == OFS_GPIO_CFG) begin
         gpio_cfg_d = reg_req.wdata[GPIO_CFG_W-1:0];
      end
      if (reg_req.wr && reg_req.addr == OFS_SLIDER_CFG) begin
         sl_cfg_d = reg_req.wdata[SL_CFG_W-1:0];
      end
      // read mux, unmapped offsets read zero
      if (reg_req.rd) begin
         if (reg_req.addr == OFS_GPIO_CFG) begin
            rdata_d[GPIO_CFG_W-1:0] = gpio_cfg_q;
         end else if (reg_req.addr == OFS_SLIDER_CFG) begin
            rdata_d[SL_CFG_W-1:0] = sl_cfg_q;
         end else if (reg_req.addr == OFS_STAT_LO) begin
            rdata_d = touch_q[STAT_LO_CH-1:0];
         end else if (reg_req.addr == OFS_STAT_HI) begin
            for (int i = STAT_LO_CH; i < NUM_CH; i++) begin
               rdata_d[i-STAT_LO_CH] = touch_q[i];
            end
            rdata_d[GPIO_STAT_BIT] = gpio_flag_q;
         end else if (reg_req.addr == OFS_SLIDER_POS) begin
            rdata_d[LOC_W-1:0] = loc_q;
            rdata_d[SL_DIR_BIT] = dir_q;
            rdata_d[SL_ACT_BIT] = sl_act_q;
            rdata_d[SL_FLAG_BIT] = sl_flag_q;
         end else if (reg_req.addr >= OFS_CAP_BASE &&
                      reg_req.addr < OFS_CAP_BASE + REG_AW'(NUM_CH)) begin
            rdata_d = cap_q[CH_W'(reg_req.addr - OFS_CAP_BASE)];
         end
      end
      // read of either status word re-arms; a new event wins
      touch_pend_d = (touch_pend_q && !stat_rd) || touch_evt;
      gpio_flag_d = (gpio_flag_q && !stat_rd) || gpio_evt;
      // only touch and gpio events reach the pin, one cycle after status
      irq_d = (touch_pend_q || gpio_flag_q) ? pol_q : !pol_q;
      // push-pull, active low unless the strap said high
      pol_d = srst ? p_s2_q : pol_q;
      // gpio pin function
      case (gpio_cfg_q[1:0])
         GPIO_FN_LOW: begin
            gout_d = 1'b0;
            goe_d = 1'b1;
         end
         GPIO_FN_HIGH: begin
            gout_d = 1'b1;
            goe_d = 1'b1;
         end
         GPIO_FN_IN: begin
            gout_d = 1'b0;
            goe_d = 1'b0;
         end
         default: begin
            gout_d = 1'b0; // disabled
            goe_d = 1'b0;
         end
      endcase
   end

   // register port, interrupt and gpio pin, registers
   always_ff @(posedge clk_sys) begin
      g_s1_q <= gpio_in;
      g_s2_q <= g_s1_q;
      g_s3_q <= g_s2_q;
      p_s1_q <= irq_pol_strap;
      p_s2_q <= p_s1_q;
      pol_q <= pol_d; // strap caught while reset is held
      if (srst) begin
         gpio_cfg_q <= GPIO_CFG_RST;
         sl_cfg_q <= SL_CFG_RST;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         touch_pend_q <= 1'b0;
         gpio_flag_q <= 1'b0;
         irq_q <= 1'b1; // high during reset, the active level if the strap selects active-high
         gout_q <= 1'b0;
         goe_q <= 1'b1;
      end else begin
         gpio_cfg_q <= gpio_cfg_d;
         sl_cfg_q <= sl_cfg_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         touch_pend_q <= touch_pend_d;
         gpio_flag_q <= gpio_flag_d;
         irq_q <= irq_d;
         gout_q <= gout_d;
         goe_q <= goe_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign conv_start = start_q;
   assign conv_chan = chan_q;
   assign gpio_out = gout_q;
   assign gpio_oe = goe_q;
   assign event_irq_n = irq_q;

endmodule : tril_core

/* File: verilog/tril_pkg.sv */
package tril_pkg;
   // register map, byte offsets on the serial register port
   localparam int REG_AW = 8;
   localparam int REG_DW = 16;
   localparam logic [REG_AW-1:0] OFS_GPIO_CFG = 8'h09;
   localparam logic [REG_AW-1:0] OFS_STAT_LO = 8'h45;
   localparam logic [REG_AW-1:0] OFS_STAT_HI = 8'h46;
   localparam logic [REG_AW-1:0] OFS_SLIDER_CFG = 8'h74;
   localparam logic [REG_AW-1:0] OFS_CAP_BASE = 8'hb0;
   localparam logic [REG_AW-1:0] OFS_SLIDER_POS = 8'hf0;
   // channel layout
   localparam int NUM_CH_DEF = 20;
   localparam int STAT_LO_CH = 16;
   localparam int GPIO_STAT_BIT = 15;
   // slider and scroll fields
   localparam int SL_ELEMS = 10;
   localparam int SL_WHEEL_BIT = 10;
   localparam int SL_CFG_W = 11;
   localparam logic [SL_CFG_W-1:0] SL_CFG_RST = 11'h000;
   localparam int LOC_W = 5;
   localparam int SL_DIR_BIT = 5;
   localparam int SL_ACT_BIT = 6;
   localparam int SL_FLAG_BIT = 15;
   // gpio configuration fields
   localparam int GPIO_CFG_W = 5;
   localparam int GPIO_TRIG_LSB = 2;
   localparam logic [GPIO_CFG_W-1:0] GPIO_CFG_RST = 5'h02;
   localparam logic [1:0] GPIO_FN_OFF = 2'h0;
   localparam logic [1:0] GPIO_FN_IN = 2'h1;
   localparam logic [1:0] GPIO_FN_LOW = 2'h2;
   localparam logic [1:0] GPIO_FN_HIGH = 2'h3;
   localparam logic [2:0] TRIG_LOW = 3'h1;
   localparam logic [2:0] TRIG_HIGH = 3'h2;
   localparam logic [2:0] TRIG_FALL = 3'h5;
   localparam logic [2:0] TRIG_RISE = 3'h6;
   localparam logic [2:0] TRIG_BOTH = 3'h7;
   // sequencer states
   typedef enum logic [0:0] {
      SEQ_SCAN = 1'b0,
      SEQ_WAIT = 1'b1
   } tril_seq_t;
   // register request from the serial front end
   typedef struct packed {
      logic rd;
      logic wr;
      logic [REG_AW-1:0] addr;
      logic [REG_DW-1:0] wdata;
   } tril_reg_req_t;
   // one result from the capacitance converter
   typedef struct packed {
      logic done;
      logic touched;
      logic [REG_DW-1:0] delta;
   } tril_conv_res_t;
endpackage : tril_pkg
